// >>> design/fpea_pkg.sv
// How it works
// - an erase is armed by writing the erase set-up code and starts only when that same write is repeated.
// - before erasing, every byte of the array is programmed to all zeros with the normal program procedure.
// - erase verify writes its set-up code while the address of the byte under check is on the address pins.
// - after each erase-verify set-up one read is made and the byte counts as erased only if it reads all ones.
// - erase verify starts at address zero and walks up one byte at a time, stopping at the first failing byte.
// - a failing byte's address is kept, another erase is issued, and verify resumes from that kept address.
// - erase attempts are capped at 1000 for the commercial grade and at 6000 for the extended grades.
// - programming writes the program set-up code, then one more write carrying the target address and data.
// - a byte is programmed by fixed 10 us pulses, each followed by a verify, until the verify matches.
// - no byte gets more than 25 programming pulses; reaching that count without a match is a failure.
// - after each pulse the program-verify set-up code is written, then a read is compared with the data.
// - an abort writes the all-ones reset code twice, then the read command.
// - the memory is in read mode after power up or after the read command is written.
package fpea_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // command codes written to the memory, plus the erased and all-zero data values
  localparam logic [7:0] FPEA_CMD_READ = 8'h00;
  localparam logic [7:0] FPEA_CMD_ERASE = 8'h20;
  localparam logic [7:0] FPEA_CMD_PROG = 8'h40;
  localparam logic [7:0] FPEA_CMD_EVFY = 8'ha0;
  localparam logic [7:0] FPEA_CMD_PVFY = 8'hc0;
  localparam logic [7:0] FPEA_CMD_RESET = 8'hff;
  localparam logic [7:0] FPEA_ERASED = 8'hff;
  localparam logic [7:0] FPEA_ZERO = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // retry limits
  localparam int FPEA_PG_MAX = 25;
  localparam int FPEA_ER_MAX_COM = 1000;
  localparam int FPEA_ER_MAX_EXT = 6000;

  ////////////////////////////////////////////////////////////////////////////
  // timing in ns and derived cycle counts at 40 MHz
  localparam int FPEA_CLK_NS = 25;
  localparam int FPEA_T_WP_NS = 60;
  localparam int FPEA_T_WC_NS = 120;
  localparam int FPEA_T_ACC_NS = 120;
  localparam int FPEA_T_DF_NS = 40;
  localparam int FPEA_T_WHGL_NS = 6000;
  localparam int FPEA_T_PROG_NS = 10000;
  localparam int FPEA_T_ERASE_NS = 9500000;
  localparam int FPEA_WP_CYC = (FPEA_T_WP_NS + FPEA_CLK_NS - 1) / FPEA_CLK_NS;
  localparam int FPEA_WH_CYC = (FPEA_T_WC_NS - FPEA_T_WP_NS + FPEA_CLK_NS - 1) / FPEA_CLK_NS;
  localparam int FPEA_ACC_CYC = (FPEA_T_ACC_NS + FPEA_CLK_NS - 1) / FPEA_CLK_NS;
  localparam int FPEA_DF_CYC = (FPEA_T_DF_NS + FPEA_CLK_NS - 1) / FPEA_CLK_NS;
  localparam int FPEA_RECOV_CYC = (FPEA_T_WHGL_NS + FPEA_CLK_NS - 1) / FPEA_CLK_NS;
  localparam int FPEA_PROG_CYC = (FPEA_T_PROG_NS + FPEA_CLK_NS - 1) / FPEA_CLK_NS;
  localparam int FPEA_ERASE_CYC = (FPEA_T_ERASE_NS + FPEA_CLK_NS - 1) / FPEA_CLK_NS;
  localparam int FPEA_WAIT_W = 20;

  ////////////////////////////////////////////////////////////////////////////
  // user operations
  typedef enum logic [1:0] {
    FPEA_OP_PROG = 2'b01,
    FPEA_OP_ERASE = 2'b10
  } fpea_op_t;

endpackage

// >>> design/fpea_cyc_if.sv
`timescale 1ns/1ps
`default_nettype none
// one bus cycle request from the sequencer to the cycle engine
interface fpea_cyc_if #(parameter int AW = 15);
  logic req;
  logic rd;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic [fpea_pkg::FPEA_WAIT_W-1:0] post;
  logic ack;
  logic [7:0] rdata;
  modport seq (output req, rd, addr, wdata, post, input ack, rdata);
  modport eng (input req, rd, addr, wdata, post, output ack, rdata);
endinterface
`default_nettype wire

// >>> design/fpea_cycle_engine.sv
`timescale 1ns/1ps
`default_nettype none
module fpea_cycle_engine import fpea_pkg::*; #(
  parameter int AW = 15
) (
  input wire logic core_clk, // system clock
  input wire logic resetn, // async reset, active low
  fpea_cyc_if.eng cyc, // cycle requests
  output logic [AW-1:0] fl_addr, // memory address
  output logic [7:0] fl_dq_o, // data driven to memory
  output logic fl_dq_oe, // high while driving data
  input wire logic [7:0] fl_dq_i, // data from memory
  output logic fl_ce_n, // chip enable, low active
  output logic fl_oe_n, // output enable, low active
  output logic fl_we_n // write enable, low active
);

  typedef enum logic [2:0] {
    FPEA_E_IDLE = 3'b000,
    FPEA_E_WLOW = 3'b001,
    FPEA_E_WHIGH = 3'b010,
    FPEA_E_RACC = 3'b011,
    FPEA_E_RREL = 3'b100,
    FPEA_E_POST = 3'b101
  } fpea_eng_t;

  fpea_eng_t st_r;
  logic [FPEA_WAIT_W-1:0] cnt_r;
  logic [FPEA_WAIT_W-1:0] post_r;

  ////////////////////////////////////////////////////////////////////////////
  // pin phase machine; a write holds we low for the pulse width, then high
  // for the rest of the cycle, then waits the requested settle time
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= FPEA_E_IDLE;
      cnt_r <= '0;
      post_r <= '0;
      fl_addr <= '0;
      fl_dq_o <= 8'h00;
      fl_dq_oe <= 1'b0;
      fl_ce_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_we_n <= 1'b1;
      cyc.ack <= 1'b0;
      cyc.rdata <= 8'h00;
    end else begin
      cyc.ack <= 1'b0;
      case (st_r)
        FPEA_E_IDLE: begin
          if (cyc.req) begin
            fl_addr <= cyc.addr;
            post_r <= cyc.post;
            fl_ce_n <= 1'b0;
            if (cyc.rd) begin
              fl_oe_n <= 1'b0;
              cnt_r <= FPEA_WAIT_W'(FPEA_ACC_CYC - 1);
              st_r <= FPEA_E_RACC;
            end else begin
              fl_dq_o <= cyc.wdata;
              fl_dq_oe <= 1'b1;
              fl_we_n <= 1'b0;
              cnt_r <= FPEA_WAIT_W'(FPEA_WP_CYC - 1);
              st_r <= FPEA_E_WLOW;
            end
          end
        end
        FPEA_E_WLOW: begin
          if (cnt_r == '0) begin
            fl_we_n <= 1'b1;
            cnt_r <= FPEA_WAIT_W'(FPEA_WH_CYC - 1);
            st_r <= FPEA_E_WHIGH;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        FPEA_E_WHIGH: begin
          if (cnt_r == '0) begin
            fl_ce_n <= 1'b1;
            fl_dq_oe <= 1'b0;
            cnt_r <= post_r;
            st_r <= FPEA_E_POST;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        FPEA_E_RACC: begin
          if (cnt_r == '0) begin
            cyc.rdata <= fl_dq_i;
            fl_oe_n <= 1'b1;
            fl_ce_n <= 1'b1;
            cnt_r <= FPEA_WAIT_W'(FPEA_DF_CYC - 1);
            st_r <= FPEA_E_RREL;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        FPEA_E_RREL: begin
          if (cnt_r == '0) begin
            cyc.ack <= 1'b1;
            st_r <= FPEA_E_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        FPEA_E_POST: begin
          if (cnt_r == '0) begin
            cyc.ack <= 1'b1;
            st_r <= FPEA_E_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: st_r <= FPEA_E_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks on the pin timing
  // write strobe width
  property p_we_width;
    @(posedge core_clk) disable iff (!resetn)
    $fell(fl_we_n) |-> (!fl_we_n && !fl_ce_n && fl_dq_oe) [*3] ##1 fl_we_n;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe width wrong");

  property p_no_contention;
    @(posedge core_clk) disable iff (!resetn)
    !(fl_dq_oe && !fl_oe_n);
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("data bus contention");

endmodule
`default_nettype wire

// >>> design/fpea_flash_seq.sv
`timescale 1ns/1ps
`default_nettype none
module fpea_flash_seq import fpea_pkg::*; #(
  parameter int AW = 15,
  parameter int ERASE_CYC = FPEA_ERASE_CYC,
  parameter int ER_MAX_COM = FPEA_ER_MAX_COM,
  parameter int ER_MAX_EXT = FPEA_ER_MAX_EXT,
  parameter int PG_MAX = FPEA_PG_MAX
) (
  input wire logic core_clk, // 40 MHz clock
  input wire logic resetn, // async reset, active low
  input wire logic cmd_valid, // start pulse, taken when idle
  input wire logic [1:0] cmd_op, // program byte or chip erase
  input wire logic [AW-1:0] cmd_addr, // byte address to program
  input wire logic [7:0] cmd_data, // byte to program
  input wire logic grade_ext, // high for extended grades
  output logic busy, // sequence running
  output logic done, // one-cycle end pulse
  output logic fail, // last sequence failed
  output logic [AW-1:0] fail_addr, // address that failed
  output logic [AW-1:0] fl_addr, // memory address pins
  output logic [7:0] fl_dq_o, // data driven to memory
  output logic fl_dq_oe, // high while driving data
  input wire logic [7:0] fl_dq_i, // data from memory
  output logic fl_ce_n, // chip enable
  output logic fl_oe_n, // output enable
  output logic fl_we_n // write enable
);

  typedef enum logic [3:0] {
    FPEA_S_IDLE = 4'b0000,
    FPEA_S_PG_SET = 4'b0001,
    FPEA_S_PG_DAT = 4'b0010,
    FPEA_S_PV_SET = 4'b0011,
    FPEA_S_PV_RD = 4'b0100,
    FPEA_S_ER_SET1 = 4'b0101,
    FPEA_S_ER_SET2 = 4'b0110,
    FPEA_S_EV_SET = 4'b0111,
    FPEA_S_EV_RD = 4'b1000,
    FPEA_S_RST1 = 4'b1001,
    FPEA_S_RST2 = 4'b1010,
    FPEA_S_RDCMD = 4'b1011
  } fpea_state_t;

  localparam logic [AW-1:0] ADDR_LAST = {AW{1'b1}};

  fpea_cyc_if #(.AW(AW)) cyc ();

  fpea_state_t st_r;
  logic wait_r;
  logic erasing_r;
  logic grade_r;
  logic bad_r;
  logic [AW-1:0] addr_r;
  logic [7:0] data_r;
  logic [4:0] pulse_r;
  logic [12:0] ecnt_r;
  logic [12:0] elimit;

  assign elimit = grade_r ? 13'(ER_MAX_EXT) : 13'(ER_MAX_COM);

  ////////////////////////////////////////////////////////////////////////////
  // request fields for the cycle issued in each state
  always_comb begin
    cyc.rd = 1'b0;
    cyc.addr = addr_r;
    cyc.wdata = FPEA_CMD_RESET;
    cyc.post = '0;
    case (st_r)
      FPEA_S_PG_SET: cyc.wdata = FPEA_CMD_PROG;
      FPEA_S_PG_DAT: begin
        cyc.wdata = data_r;
        cyc.post = FPEA_WAIT_W'(FPEA_PROG_CYC);
      end
      FPEA_S_PV_SET: begin
        cyc.wdata = FPEA_CMD_PVFY;
        cyc.post = FPEA_WAIT_W'(FPEA_RECOV_CYC);
      end
      FPEA_S_ER_SET1: cyc.wdata = FPEA_CMD_ERASE;
      FPEA_S_ER_SET2: begin
        cyc.wdata = FPEA_CMD_ERASE;
        cyc.post = FPEA_WAIT_W'(ERASE_CYC);
      end
      FPEA_S_EV_SET: begin
        cyc.wdata = FPEA_CMD_EVFY;
        cyc.post = FPEA_WAIT_W'(FPEA_RECOV_CYC);
      end
      FPEA_S_PV_RD, FPEA_S_EV_RD: cyc.rd = 1'b1;
      FPEA_S_RDCMD: cyc.wdata = FPEA_CMD_READ;
      default: cyc.wdata = FPEA_CMD_RESET;
    endcase
  end

  assign cyc.req = (st_r != FPEA_S_IDLE) && !wait_r;

  ////////////////////////////////////////////////////////////////////////////
  // pin cycle engine
  fpea_cycle_engine #(.AW(AW)) u_eng (
    .core_clk(core_clk),
    .resetn(resetn),
    .cyc(cyc),
    .fl_addr(fl_addr),
    .fl_dq_o(fl_dq_o),
    .fl_dq_oe(fl_dq_oe),
    .fl_dq_i(fl_dq_i),
    .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // issue handshake: one request per state, then wait for its ack
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wait_r <= 1'b0;
    end else if (cyc.ack) begin
      wait_r <= 1'b0;
    end else if (cyc.req) begin
      wait_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // algorithm sequencer
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= FPEA_S_IDLE;
      erasing_r <= 1'b0;
      grade_r <= 1'b0;
      bad_r <= 1'b0;
      addr_r <= '0;
      data_r <= 8'h00;
      pulse_r <= 5'h00;
      ecnt_r <= 13'h0000;
    end else begin
      case (st_r)
        FPEA_S_IDLE: begin
          if (cmd_valid && (cmd_op == FPEA_OP_PROG || cmd_op == FPEA_OP_ERASE)) begin
            grade_r <= grade_ext;
            bad_r <= 1'b0;
            pulse_r <= 5'h00;
            ecnt_r <= 13'h0000;
            st_r <= FPEA_S_PG_SET;
            if (cmd_op == FPEA_OP_ERASE) begin
              erasing_r <= 1'b1;
              addr_r <= '0;
              data_r <= FPEA_ZERO;
            end else begin
              erasing_r <= 1'b0;
              addr_r <= cmd_addr;
              data_r <= cmd_data;
            end
          end
        end
        // set-up then address and data write
        FPEA_S_PG_SET: if (cyc.ack) st_r <= FPEA_S_PG_DAT;
        FPEA_S_PG_DAT: begin
          if (cyc.ack) begin
            pulse_r <= pulse_r + 5'h01;
            st_r <= FPEA_S_PV_SET;
          end
        end
        FPEA_S_PV_SET: if (cyc.ack) st_r <= FPEA_S_PV_RD;
        FPEA_S_PV_RD: begin
          if (cyc.ack) begin
            if (cyc.rdata == data_r) begin
              pulse_r <= 5'h00;
              if (!erasing_r) begin
                st_r <= FPEA_S_RST1;
              end else if (addr_r == ADDR_LAST) begin
                addr_r <= '0;
                st_r <= FPEA_S_ER_SET1;
              end else begin
                addr_r <= addr_r + 1'b1;
                st_r <= FPEA_S_PG_SET;
              end
            end else if (pulse_r == 5'(PG_MAX)) begin
              bad_r <= 1'b1;
              st_r <= FPEA_S_RST1;
            end else begin
              st_r <= FPEA_S_PG_SET;
            end
          end
        end
        FPEA_S_ER_SET1: if (cyc.ack) st_r <= FPEA_S_ER_SET2;
        FPEA_S_ER_SET2: begin
          if (cyc.ack) begin
            ecnt_r <= ecnt_r + 13'h0001;
            st_r <= FPEA_S_EV_SET;
          end
        end
        FPEA_S_EV_SET: if (cyc.ack) st_r <= FPEA_S_EV_RD;
        FPEA_S_EV_RD: begin
          if (cyc.ack) begin
            // byte erased only when all ones
            if (cyc.rdata == FPEA_ERASED) begin
              // walk upward to the last byte
              if (addr_r == ADDR_LAST) begin
                st_r <= FPEA_S_RST1;
              end else begin
                addr_r <= addr_r + 1'b1;
                st_r <= FPEA_S_EV_SET;
              end
            end else if (ecnt_r >= elimit) begin
              bad_r <= 1'b1;
              st_r <= FPEA_S_RST1;
            end else begin
              st_r <= FPEA_S_ER_SET1;
            end
          end
        end
        // reset code twice then read command
        FPEA_S_RST1: if (cyc.ack) st_r <= FPEA_S_RST2;
        FPEA_S_RST2: if (cyc.ack) st_r <= FPEA_S_RDCMD;
        FPEA_S_RDCMD: if (cyc.ack) st_r <= FPEA_S_IDLE;
        default: st_r <= FPEA_S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status outputs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      fail_addr <= '0;
    end else begin
      done <= 1'b0;
      if (st_r == FPEA_S_IDLE && cmd_valid && (cmd_op == FPEA_OP_PROG || cmd_op == FPEA_OP_ERASE)) begin
        busy <= 1'b1;
        fail <= 1'b0;
      end else if (st_r == FPEA_S_RDCMD && cyc.ack) begin
        // report failure after read mode restored
        busy <= 1'b0;
        done <= 1'b1;
        fail <= bad_r;
        if (bad_r) fail_addr <= addr_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_erase_twice;
    @(posedge core_clk) disable iff (!resetn)
    (st_r == FPEA_S_ER_SET2 && cyc.req) |-> $past(st_r, 2) == FPEA_S_ER_SET1 || $past(st_r) == FPEA_S_ER_SET1;
  endproperty
  a_erase_twice: assert property (p_erase_twice) else $error("erase started without set-up");

  property p_ev_addr;
    @(posedge core_clk) disable iff (!resetn)
    (st_r == FPEA_S_EV_SET && cyc.req) |-> cyc.wdata == FPEA_CMD_EVFY && cyc.addr == addr_r;
  endproperty
  a_ev_addr: assert property (p_ev_addr) else $error("erase verify set-up malformed");

  property p_ev_fail_reerase;
    @(posedge core_clk) disable iff (!resetn)
    (st_r == FPEA_S_EV_RD && cyc.ack && cyc.rdata != FPEA_ERASED) |=>
      (st_r == FPEA_S_ER_SET1 || st_r == FPEA_S_RST1) && $stable(addr_r);
  endproperty
  a_ev_fail_reerase: assert property (p_ev_fail_reerase) else $error("bad erase verify handling");

  property p_ev_pass_step;
    @(posedge core_clk) disable iff (!resetn)
    (st_r == FPEA_S_EV_RD && cyc.ack && cyc.rdata == FPEA_ERASED && addr_r != ADDR_LAST) |=>
      addr_r == $past(addr_r) + 1'b1 && st_r == FPEA_S_EV_SET;
  endproperty
  a_ev_pass_step: assert property (p_ev_pass_step) else $error("erase verify did not advance");

  property p_erase_limit;
    @(posedge core_clk) disable iff (!resetn)
    ecnt_r <= elimit;
  endproperty
  a_erase_limit: assert property (p_erase_limit) else $error("erase attempts exceed limit");

  property p_pulse_limit;
    @(posedge core_clk) disable iff (!resetn)
    pulse_r <= 5'(PG_MAX);
  endproperty
  a_pulse_limit: assert property (p_pulse_limit) else $error("program pulses exceed limit");

  property p_pv_after_pulse;
    @(posedge core_clk) disable iff (!resetn)
    (st_r == FPEA_S_PG_DAT && cyc.ack) |=> st_r == FPEA_S_PV_SET && cyc.wdata == FPEA_CMD_PVFY;
  endproperty
  a_pv_after_pulse: assert property (p_pv_after_pulse) else $error("no verify after pulse");

  property p_abort_twice;
    @(posedge core_clk) disable iff (!resetn)
    (st_r == FPEA_S_RST1 && cyc.ack) |=> st_r == FPEA_S_RST2 && cyc.wdata == FPEA_CMD_RESET;
  endproperty
  a_abort_twice: assert property (p_abort_twice) else $error("reset code not doubled");

  property p_fail_report;
    @(posedge core_clk) disable iff (!resetn)
    $rose(fail) |-> done && !busy && $past(st_r) == FPEA_S_RDCMD;
  endproperty
  a_fail_report: assert property (p_fail_report) else $error("failure reported out of order");

  c_prog_done: cover property (@(posedge core_clk) disable iff (!resetn) done && !fail && !erasing_r);
  c_erase_done: cover property (@(posedge core_clk) disable iff (!resetn) done && !fail && erasing_r);
  c_reerase: cover property (@(posedge core_clk) disable iff (!resetn)
    st_r == FPEA_S_EV_RD && cyc.ack && cyc.rdata != FPEA_ERASED);
  c_fail: cover property (@(posedge core_clk) disable iff (!resetn) done && fail);

endmodule
`default_nettype wire

// >>> verification/fpea_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural byte-wide flash memory on the far side of the sequencer
module fpea_flash_model import fpea_pkg::*; #(
  parameter int AW = 3
) (
  input wire logic [AW-1:0] fl_addr, // address pins
  input wire logic [7:0] fl_dq_o, // data from sequencer
  input wire logic fl_dq_oe, // sequencer drives data
  input wire logic fl_ce_n, // chip enable
  input wire logic fl_oe_n, // output enable
  input wire logic fl_we_n, // write enable
  output logic [7:0] fl_dq_i // resolved data bus
);
  typedef enum logic [2:0] {M_READ, M_ESET, M_ERASE, M_EVFY, M_PSET, M_PROG, M_PVFY, M_RST1} fpea_md_t;
  fpea_md_t md = M_READ;
  logic [7:0] mem [2**AW];
  int pfail [2**AW];
  int efail [2**AW];
  int n_pulse = 0;
  int n_erase = 0;
  int n_evfy = 0;
  int bad = 0;
  logic [23:0] hist = 24'h000000;
  logic fresh = 1'b0;
  logic [AW-1:0] pg_a = '0;
  logic [AW-1:0] ev_a = '0;
  realtime t_pg = 0.0;
  logic [7:0] rd;
  logic [7:0] last = 8'h00;
  logic drv;

  ////////////////////////////////////////////////////////////////////////////
  // array starts erased, every cell behaves
  initial begin
    for (int i = 0; i < 2**AW; i++) begin
      mem[i] = 8'hff;
      pfail[i] = 0;
      efail[i] = 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command register, latched on write strobe rising edge
  always @(posedge fl_we_n) begin
    if (fl_ce_n === 1'b0) begin
      hist = {hist[15:0], fl_dq_o};
      case (md)
        M_PSET: begin
          pg_a = fl_addr;
          md = M_PROG;
          fresh = 1'b1;
          n_pulse++;
          t_pg = $realtime;
          if (pfail[fl_addr] > 0) pfail[fl_addr]--;
          else mem[fl_addr] = mem[fl_addr] & fl_dq_o;
        end
        M_ESET: begin
          if (fl_dq_o === FPEA_CMD_ERASE) begin
            if (fresh) foreach (mem[i]) if (mem[i] !== FPEA_ZERO) bad++;
            fresh = 1'b0;
            n_erase++;
            md = M_ERASE;
            foreach (mem[i]) if (efail[i] > 0) efail[i]--; else mem[i] = FPEA_ERASED;
          end else md = M_READ;
        end
        default: begin
          if (md == M_PROG && $realtime - t_pg < 9500.0) bad++;
          case (fl_dq_o)
            FPEA_CMD_READ: md = M_READ;
            FPEA_CMD_ERASE: md = M_ESET;
            FPEA_CMD_PROG: md = M_PSET;
            FPEA_CMD_EVFY: begin
              ev_a = fl_addr;
              n_evfy++;
              md = M_EVFY;
            end
            FPEA_CMD_PVFY: md = M_PVFY;
            FPEA_CMD_RESET: md = (md == M_RST1) ? M_READ : M_RST1;
            default: bad++;
          endcase
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data: latched byte in the verify modes, addressed byte in read mode, inverse otherwise
  always @* begin
    case (md)
      M_EVFY: rd = mem[ev_a];
      M_PVFY: rd = mem[pg_a];
      M_READ: rd = mem[fl_addr];
      default: rd = ~mem[fl_addr];
    endcase
  end

  // released bus shows the inverse of the last driven value
  assign drv = (fl_ce_n === 1'b0) && (fl_oe_n === 1'b0);
  always @* if (drv) last = rd;
  assign fl_dq_i = fl_dq_oe ? fl_dq_o : (drv ? rd : ~last);
endmodule
`default_nettype wire

// >>> verification/flash_program_erase_algorithm_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_algorithm_tb import fpea_pkg::*; ();
  localparam int AW = 3;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'b00;
  logic [AW-1:0] cmd_addr = '0;
  logic [7:0] cmd_data = 8'h00;
  logic grade_ext = 1'b0;
  logic busy, done, fail, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n;
  logic [AW-1:0] fail_addr, fl_addr;
  logic [7:0] fl_dq_o, fl_dq_i;
  int n_fail = 0;
  int num_checks = 0;
  int p0, e0, v0;
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_fail++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end

  fpea_flash_seq #(.AW(AW), .ERASE_CYC(20), .ER_MAX_COM(2), .ER_MAX_EXT(4), .PG_MAX(3)) i_fpea_flash_seq (
    .core_clk, .resetn, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .grade_ext, .busy, .done, .fail,
    .fail_addr, .fl_addr, .fl_dq_o, .fl_dq_oe, .fl_dq_i, .fl_ce_n, .fl_oe_n, .fl_we_n);
  fpea_flash_model #(.AW(AW)) i_fpea_flash_model (
    .fl_addr, .fl_dq_o, .fl_dq_oe, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_dq_i);

  // clock and reset
  initial forever #12.5 core_clk = ~core_clk;
  initial begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
  end

  // one user command, waited on and closed out
  task automatic run(input logic [1:0] op, input logic [AW-1:0] a, input logic [7:0] d, input logic ext);
    int n;
    n = 0;
    p0 = i_fpea_flash_model.n_pulse;
    e0 = i_fpea_flash_model.n_erase;
    v0 = i_fpea_flash_model.n_evfy;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    grade_ext <= ext;
    cmd_data <= d;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    #1;
    `CHK("busy", 1'b1, busy)
    while (done !== 1'b1 && n < 20000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    `CHK("done", 1'b1, done)
    `CHK("busy_end", 1'b0, busy)
    `CHK("tail", 24'hffff00, i_fpea_flash_model.hist)
    `CHK("mode", 3'h0, i_fpea_flash_model.md)
    `CHK("bad", 0, i_fpea_flash_model.bad)
  endtask

  task automatic t_prog();
    i_fpea_flash_model.pfail[2] = 2;
    run(FPEA_OP_PROG, 3'h2, 8'h3c, 1'b0);
    `CHK("fail", 1'b0, fail)
    `CHK("byte", 8'h3c, i_fpea_flash_model.mem[2])
    `CHK("pulses", 3, i_fpea_flash_model.n_pulse - p0)
    $display("test prog end");
  endtask

  task automatic t_pfail();
    i_fpea_flash_model.pfail[5] = 3;
    run(FPEA_OP_PROG, 3'h5, 8'h81, 1'b0);
    `CHK("fail", 1'b1, fail)
    `CHK("fail_addr", 3'h5, fail_addr)
    `CHK("pulses", 3, i_fpea_flash_model.n_pulse - p0)
    $display("test program limit end");
  endtask

  task automatic t_erase();
    i_fpea_flash_model.efail[5] = 1;
    run(FPEA_OP_ERASE, 3'h0, 8'h00, 1'b0);
    `CHK("fail", 1'b0, fail)
    `CHK("preprog", 8, i_fpea_flash_model.n_pulse - p0)
    `CHK("erases", 2, i_fpea_flash_model.n_erase - e0)
    `CHK("verifies", 9, i_fpea_flash_model.n_evfy - v0)
    for (int i = 0; i < 8; i++) `CHK("erased", 8'hff, i_fpea_flash_model.mem[i])
    $display("test erase end");
  endtask

  task automatic t_elim();
    i_fpea_flash_model.efail[6] = 100;
    run(FPEA_OP_ERASE, 3'h0, 8'h00, 1'b0);
    `CHK("fail", 1'b1, fail)
    `CHK("fail_addr", 3'h6, fail_addr)
    `CHK("erases", 2, i_fpea_flash_model.n_erase - e0)
    `CHK("verifies", 8, i_fpea_flash_model.n_evfy - v0)
    run(FPEA_OP_ERASE, 3'h0, 8'h00, 1'b1);
    `CHK("erases_ext", 4, i_fpea_flash_model.n_erase - e0)
    `CHK("fail_ext", 1'b1, fail)
    i_fpea_flash_model.efail[6] = 0;
    $display("test erase limit end");
  endtask

  task automatic t_refuse();
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= 2'b11;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK("idle", 1'b0, busy)
    $display("test bad op end");
  endtask

  task automatic results();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (60000) @(posedge core_clk);
    n_fail++;
    results();
  end

  // main sequence
  initial begin
    wait (resetn === 1'b1);
    t_refuse();
    t_prog();
    t_pfail();
    t_erase();
    t_elim();
    results();
  end
endmodule
`default_nettype wire
